// file: rtl/pit8_timer.sv
// Function
// [RL1] 8-bit up-counter against 8-bit compare, selectable source, prescaler, interrupt logic.
// [RL2] Reset stops and clears count, clears compare value, turns prescaler off.
// [RL3] After reset the low-power 1 kHz oscillator is the selected source.
// [RL4] Prescaler stays off while prescale select is zero; nonzero starts it.
// [RL5] Software selects low-power, external or internal reference clock.
// [RL6] Writing a different source select clears prescaler and count.
// [RL7] Divide ratio comes from prescale select and source select low bit.
// [RL8] Writing a different prescale select clears prescaler and count.
// [RL9] Compare value accepts any value 0x00 through 0xFF.
// [RL10] Count advances per prescaler tick, wraps to 0x00 after equalling compare.
// [RL11] Wrap flag sets when count steps from compare value to 0x00.
// [RL12] Any compare register write clears prescaler and count.
// [RL13] Interrupt request equals wrap flag and enable both set.
// [RL14] Writing one to the flag bit clears flag and request.
// [RL15] Source code 00 low-power, 01 external, 1x internal reference.
// [RL16] Fixed divide tables per source low bit; code zero is off.
// [RL17] Compare value 0x00 sets the flag on every prescaler tick.
// [RL18] Count is readable as 8 bits; it cannot be written.
// [RL19] Writing zero to the flag leaves it; only a wrap sets it.
// [RL20] Source switch gives no false tick; restart cleanly from zero.
`include "pit8_consts.svh"
`default_nettype none

module pit8_timer (
   // Clock, reset and enable.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // Clock sources, sampled as levels.
   input wire logic i_low_power_osc_clock,
   input wire logic i_external_ref_clock,
   input wire logic i_internal_ref_clock,
   // Status and control byte write.
   input wire logic i_control_write,
   input wire logic [7:0] i_control_wdata,
   // Compare value write.
   input wire logic i_compare_write,
   input wire logic [7:0] i_compare_wdata,
   // Readable state.
   output logic [7:0] o_tick_status_control,
   output logic [7:0] o_tick_count,
   output logic [7:0] o_wrap_compare_value,
   output logic o_wrap_flag,
   output logic o_wrap_irq
);

   pit8_pkg::pit8_main_state_t s_q;
   pit8_pkg::pit8_main_state_t s_d;
   logic restart;
   logic wrap;
   logic src_level;
   logic pre_tick;
   logic [`PIT8_DIV_W-1:0] divide;

   // Both tables give zero for code zero, which the prescaler treats as stopped. [RL4]
   function automatic logic [`PIT8_DIV_W-1:0] divide_short(input logic [3:0] ps);
      logic [`PIT8_DIV_W-1:0] d;
      case (ps)
         4'h1: d = `PIT8_DIV_SHORT_1;
         4'h2: d = `PIT8_DIV_SHORT_2;
         4'h3: d = `PIT8_DIV_SHORT_3;
         4'h4: d = `PIT8_DIV_SHORT_4;
         4'h5: d = `PIT8_DIV_SHORT_5;
         4'h6: d = `PIT8_DIV_SHORT_6;
         4'h7: d = `PIT8_DIV_SHORT_7;
         4'h8: d = `PIT8_DIV_SHORT_8;
         4'h9: d = `PIT8_DIV_SHORT_9;
         4'hA: d = `PIT8_DIV_SHORT_A;
         4'hB: d = `PIT8_DIV_SHORT_B;
         4'hC: d = `PIT8_DIV_SHORT_C;
         4'hD: d = `PIT8_DIV_SHORT_D;
         4'hE: d = `PIT8_DIV_SHORT_E;
         4'hF: d = `PIT8_DIV_SHORT_F;
         default: d = `PIT8_DIV_OFF;
      endcase
      return d;
   endfunction : divide_short

   function automatic logic [`PIT8_DIV_W-1:0] divide_long(input logic [3:0] ps);
      logic [`PIT8_DIV_W-1:0] d;
      case (ps)
         4'h1: d = `PIT8_DIV_LONG_1;
         4'h2: d = `PIT8_DIV_LONG_2;
         4'h3: d = `PIT8_DIV_LONG_3;
         4'h4: d = `PIT8_DIV_LONG_4;
         4'h5: d = `PIT8_DIV_LONG_5;
         4'h6: d = `PIT8_DIV_LONG_6;
         4'h7: d = `PIT8_DIV_LONG_7;
         4'h8: d = `PIT8_DIV_LONG_8;
         4'h9: d = `PIT8_DIV_LONG_9;
         4'hA: d = `PIT8_DIV_LONG_A;
         4'hB: d = `PIT8_DIV_LONG_B;
         4'hC: d = `PIT8_DIV_LONG_C;
         4'hD: d = `PIT8_DIV_LONG_D;
         4'hE: d = `PIT8_DIV_LONG_E;
         4'hF: d = `PIT8_DIV_LONG_F;
         default: d = `PIT8_DIV_OFF;
      endcase
      return d;
   endfunction : divide_long

   // Sources 01 and 11 share the long table, since only the low select bit picks it.
   function automatic logic [`PIT8_DIV_W-1:0] divide_of(input logic src_lo, input logic [3:0] ps);
      logic [`PIT8_DIV_W-1:0] d;
      if (src_lo) begin
         d = divide_long(ps);
      end else begin
         d = divide_short(ps);
      end
      return d;
   endfunction : divide_of

   function automatic logic [1:0] src_field(input logic [7:0] wdata);
      return wdata[`PIT8_SRC_HI:`PIT8_SRC_LO];
   endfunction : src_field

   function automatic logic [3:0] ps_field(input logic [7:0] wdata);
      return wdata[`PIT8_PS_HI:`PIT8_PS_LO];
   endfunction : ps_field

   // Rewriting the same selection keeps counting, so software may toggle the enable freely.
   function automatic logic ctrl_restarts(input logic [7:0] wdata, input logic [1:0] src, input logic [3:0] ps);
      logic r;
      r = 1'b0;
      if (src_field(wdata) != src) begin
         r = 1'b1; // [RL6] [RL20]
      end
      if (ps_field(wdata) != ps) begin
         r = 1'b1; // [RL8]
      end
      return r;
   endfunction : ctrl_restarts

   // One match decides both the return to zero and the flag.
   function automatic logic at_wrap(input logic [7:0] count, input logic [7:0] compare);
      return count == compare;
   endfunction : at_wrap

   function automatic logic [7:0] count_after_tick(input logic [7:0] count, input logic [7:0] compare);
      logic [7:0] n;
      if (at_wrap(count, compare)) begin
         n = `PIT8_RST_COUNT; // [RL10] [RL17]
      end else begin
         n = count + 8'h01; // [RL1]
      end
      return n;
   endfunction : count_after_tick

   // A wrap in the cycle of a clear leaves the flag set, so a flag clear never loses a wrap.
   function automatic logic flag_after(input logic flag, input logic clear, input logic wrap_now);
      logic f;
      f = flag;
      if (clear) begin
         f = 1'b0; // [RL14] [RL19]
      end
      if (wrap_now) begin
         f = 1'b1; // [RL11]
      end
      return f;
   endfunction : flag_after

   function automatic logic [7:0] pack_status(input logic flag, input logic [1:0] src, input logic ie,
         input logic [3:0] ps);
      logic [7:0] b;
      b = 8'h00;
      b[`PIT8_FLAG_BIT] = flag;
      b[`PIT8_SRC_HI:`PIT8_SRC_LO] = src;
      b[`PIT8_IE_BIT] = ie;
      b[`PIT8_PS_HI:`PIT8_PS_LO] = ps;
      return b;
   endfunction : pack_status

   always_comb begin
      s_d = s_q;
      restart = 1'b0;
      wrap = 1'b0;
      if (i_control_write) begin
         s_d.source_select = src_field(i_control_wdata); // [RL5]
         s_d.prescale_select = ps_field(i_control_wdata); // [RL4]
         s_d.wrap_irq_enable = i_control_wdata[`PIT8_IE_BIT];
         restart = ctrl_restarts(i_control_wdata, s_q.source_select, s_q.prescale_select); // [RL6] [RL8] [RL20]
      end
      if (i_compare_write) begin
         s_d.wrap_compare_value = i_compare_wdata; // [RL9]
         restart = 1'b1; // [RL12]
      end
      if (restart) begin
         // A tick still in flight from the old setting is dropped here.
         s_d.tick_count = `PIT8_RST_COUNT;
      end else if (pre_tick) begin
         wrap = at_wrap(s_q.tick_count, s_q.wrap_compare_value); // [RL10] [RL11]
         s_d.tick_count = count_after_tick(s_q.tick_count, s_q.wrap_compare_value); // [RL1] [RL10]
      end
      s_d.wrap_flag = flag_after(s_q.wrap_flag, i_control_write && i_control_wdata[`PIT8_FLAG_BIT], wrap);
      s_d.irq = s_d.wrap_flag && s_d.wrap_irq_enable; // [RL13]
   end

   // Next selection feeds the prescaler so a switch reloads edge history from the new source.
   always_comb begin
      case (pit8_pkg::pit8_src_t'(s_d.source_select))
         pit8_pkg::PIT8_SRC_LOW_POWER: src_level = i_low_power_osc_clock; // [RL15]
         pit8_pkg::PIT8_SRC_EXTERNAL: src_level = i_external_ref_clock;
         default: src_level = i_internal_ref_clock;
      endcase
   end

   assign divide = divide_of(s_q.source_select[0], s_q.prescale_select); // [RL16] [RL7]

   pit8_prescaler u_prescaler (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      .i_clk_en(i_clk_en),
      .i_src_level(src_level),
      .i_restart(restart),
      .i_divide(divide),
      .o_tick(pre_tick)
   );

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q.source_select <= `PIT8_RST_SRC; // [RL3]
         s_q.prescale_select <= `PIT8_RST_PS; // [RL2]
         s_q.wrap_irq_enable <= 1'b0;
         s_q.wrap_flag <= 1'b0;
         s_q.tick_count <= `PIT8_RST_COUNT;
         s_q.wrap_compare_value <= `PIT8_RST_COMPARE;
         s_q.irq <= 1'b0;
      end else if (i_clk_en) begin
         s_q <= s_d;
      end
   end

   // Count has no write path at all. [RL18]
   assign o_tick_status_control = pack_status(s_q.wrap_flag, s_q.source_select, s_q.wrap_irq_enable,
      s_q.prescale_select);
   assign o_tick_count = s_q.tick_count;
   assign o_wrap_compare_value = s_q.wrap_compare_value;
   assign o_wrap_flag = s_q.wrap_flag;
   assign o_wrap_irq = s_q.irq;

endmodule : pit8_timer

`default_nettype wire

// file: rtl/pit8_consts.svh
`ifndef PIT8_CONSTS_SVH
`define PIT8_CONSTS_SVH

// Field positions of the status and control byte.
`define PIT8_FLAG_BIT 7
`define PIT8_SRC_HI 6
`define PIT8_SRC_LO 5
`define PIT8_IE_BIT 4
`define PIT8_PS_HI 3
`define PIT8_PS_LO 0

// Reset values.
`define PIT8_RST_COUNT 8'h00
`define PIT8_RST_COMPARE 8'h00
`define PIT8_RST_PS 4'h0
`define PIT8_RST_SRC 2'h0
`define PIT8_RST_DIV_COUNT 18'h00000

// Prescaler counter width, wide enough for the largest divide of 200000.
`define PIT8_DIV_W 18
`define PIT8_DIV_OFF 18'h00000
`define PIT8_DIV_ONE 18'h00001

// Divide ratios per prescale code while the source select low bit is clear.
`define PIT8_DIV_SHORT_1 18'h00008
`define PIT8_DIV_SHORT_2 18'h00020
`define PIT8_DIV_SHORT_3 18'h00040
`define PIT8_DIV_SHORT_4 18'h00080
`define PIT8_DIV_SHORT_5 18'h00100
`define PIT8_DIV_SHORT_6 18'h00200
`define PIT8_DIV_SHORT_7 18'h00400
`define PIT8_DIV_SHORT_8 18'h00001
`define PIT8_DIV_SHORT_9 18'h00002
`define PIT8_DIV_SHORT_A 18'h00004
`define PIT8_DIV_SHORT_B 18'h0000A
`define PIT8_DIV_SHORT_C 18'h00010
`define PIT8_DIV_SHORT_D 18'h00064
`define PIT8_DIV_SHORT_E 18'h001F4
`define PIT8_DIV_SHORT_F 18'h003E8

// Divide ratios per prescale code while the source select low bit is set.
`define PIT8_DIV_LONG_1 18'h00400
`define PIT8_DIV_LONG_2 18'h00800
`define PIT8_DIV_LONG_3 18'h01000
`define PIT8_DIV_LONG_4 18'h02000
`define PIT8_DIV_LONG_5 18'h04000
`define PIT8_DIV_LONG_6 18'h08000
`define PIT8_DIV_LONG_7 18'h10000
`define PIT8_DIV_LONG_8 18'h003E8
`define PIT8_DIV_LONG_9 18'h007D0
`define PIT8_DIV_LONG_A 18'h01388
`define PIT8_DIV_LONG_B 18'h02710
`define PIT8_DIV_LONG_C 18'h04E20
`define PIT8_DIV_LONG_D 18'h0C350
`define PIT8_DIV_LONG_E 18'h186A0
`define PIT8_DIV_LONG_F 18'h30D40

`endif

// file: rtl/pit8_pkg.sv
`include "pit8_consts.svh"
`default_nettype none

package pit8_pkg;

   typedef enum logic [1:0] {
      PIT8_SRC_LOW_POWER = 2'h0,
      PIT8_SRC_EXTERNAL = 2'h1,
      PIT8_SRC_INTERNAL = 2'h2,
      PIT8_SRC_INTERNAL_ALT = 2'h3
   } pit8_src_t;

   typedef struct packed {
      logic prev_level;
      logic [`PIT8_DIV_W-1:0] div_count;
      logic tick;
   } pit8_pre_state_t;

   typedef struct packed {
      logic [1:0] source_select;
      logic [3:0] prescale_select;
      logic wrap_irq_enable;
      logic wrap_flag;
      logic [7:0] tick_count;
      logic [7:0] wrap_compare_value;
      logic irq;
   } pit8_main_state_t;

endpackage : pit8_pkg

`default_nettype wire

// file: rtl/pit8_prescaler.sv
`include "pit8_consts.svh"
`default_nettype none

module pit8_prescaler (
   // Clock, reset and enable.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // Selected source and control.
   input wire logic i_src_level,
   input wire logic i_restart,
   input wire logic [`PIT8_DIV_W-1:0] i_divide,
   // Prescaler output tick.
   output logic o_tick
);

   pit8_pkg::pit8_pre_state_t s_q;
   pit8_pkg::pit8_pre_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.prev_level = i_src_level;
      if (i_restart) begin
         // Reloading the edge history with the new source level avoids a false edge on a switch. [RL20]
         s_d.div_count = `PIT8_RST_DIV_COUNT; // [RL6] [RL8] [RL12]
      end else if (i_divide == `PIT8_DIV_OFF) begin
         s_d.div_count = `PIT8_RST_DIV_COUNT; // [RL4]
      end else if (i_src_level && !s_q.prev_level) begin
         if (s_q.div_count == i_divide - `PIT8_DIV_ONE) begin
            s_d.div_count = `PIT8_RST_DIV_COUNT;
            s_d.tick = 1'b1; // [RL7]
         end else begin
            s_d.div_count = s_q.div_count + `PIT8_DIV_ONE;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_q <= '0;
      end else if (i_clk_en) begin
         s_q <= s_d;
      end
   end

   assign o_tick = s_q.tick;

endmodule : pit8_prescaler

`default_nettype wire

// file: bench/pit8_timer_asserts.sv
`default_nettype none
module pit8_timer_asserts (
   // Clock and control.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic i_control_write,
   input wire logic [7:0] i_control_wdata,
   input wire logic i_compare_write,
   input wire logic [7:0] i_compare_wdata,
   // Observed state.
   input wire logic [7:0] o_tick_status_control,
   input wire logic [7:0] o_tick_count,
   input wire logic [7:0] o_wrap_compare_value,
   input wire logic o_wrap_flag,
   input wire logic o_wrap_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cw;
   assign cw = i_control_write && i_clk_en;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   a_reset_clear: assert property ($rose(i_reset_n) |-> o_tick_count == 8'h00 &&
      o_tick_status_control == 8'h00 && o_wrap_compare_value == 8'h00) else $error("state not clear after reset");
   a_irq_level: assert property (o_wrap_irq == (o_wrap_flag && o_tick_status_control[4]))
      else $error("irq not flag and enable");
   a_cmp_write: assert property (i_compare_write && i_clk_en |=>
      o_wrap_compare_value == $past(i_compare_wdata) && o_tick_count == 8'h00) else $error("compare write");
   a_src_restart: assert property (cw && i_control_wdata[6:5] != o_tick_status_control[6:5]
      |=> o_tick_count == 8'h00) else $error("source change kept count");
   a_ps_restart: assert property (cw && i_control_wdata[3:0] != o_tick_status_control[3:0]
      |=> o_tick_count == 8'h00) else $error("prescale change kept count");
   a_count_step: assert property ($changed(o_tick_count) |->
      o_tick_count == 8'h00 || o_tick_count == $past(o_tick_count) + 8'h01) else $error("count jumped");
   a_wrap_at_cmp: assert property ($changed(o_tick_count) && o_tick_count == 8'h00 &&
      !$past(i_control_write || i_compare_write) |-> $past(o_tick_count) == $past(o_wrap_compare_value)
      && o_wrap_flag) else $error("wrap not at compare");
   a_flag_source: assert property ($rose(o_wrap_flag) |-> o_tick_count == 8'h00)
      else $error("flag set without wrap");
   a_flag_clear: assert property (cw && i_control_wdata[7] |=> !o_wrap_flag || o_tick_count == 8'h00)
      else $error("flag not cleared");
   a_flag_keep: assert property (cw && !i_control_wdata[7] && o_wrap_flag |=> o_wrap_flag)
      else $error("flag lost on zero write");
   // A stopped prescaler may still see its count cleared by a restart, never advanced.
   a_ps_off: assert property (o_tick_status_control[3:0] == 4'h0 |=>
      o_tick_count == 8'h00 || $stable(o_tick_count)) else $error("count moved with prescaler off");
   c_wrap_irq: cover property ($rose(o_wrap_irq));
   c_cmp_write: cover property (i_compare_write && o_tick_count != 8'h00);
   c_src_change: cover property (cw && i_control_wdata[6:5] != o_tick_status_control[6:5]);
endmodule : pit8_timer_asserts
bind pit8_timer pit8_timer_asserts u_pit8_timer_asserts (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
   .i_clk_en(i_clk_en), .i_control_write(i_control_write), .i_control_wdata(i_control_wdata),
   .i_compare_write(i_compare_write), .i_compare_wdata(i_compare_wdata),
   .o_tick_status_control(o_tick_status_control), .o_tick_count(o_tick_count),
   .o_wrap_compare_value(o_wrap_compare_value), .o_wrap_flag(o_wrap_flag), .o_wrap_irq(o_wrap_irq));
`default_nettype wire

// file: bench/pit8_timer_tb.sv
`default_nettype none
module pit8_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cwr = 1'b0;
   logic mwr = 1'b0;
   logic en = 1'b1;
   logic [7:0] wd = 8'h00;
   logic [2:0] src = 3'h0;
   logic [7:0] st, cnt, cmp;
   logic flag, irq;
   int n_errors = 0;
   int checks = 0;
   always #2 clk = ~clk;
   pit8_timer u_pit8_timer (.i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(en),
      .i_low_power_osc_clock(src[0]), .i_external_ref_clock(src[1]), .i_internal_ref_clock(src[2]),
      .i_control_write(cwr), .i_control_wdata(wd), .i_compare_write(mwr), .i_compare_wdata(wd),
      .o_tick_status_control(st), .o_tick_count(cnt), .o_wrap_compare_value(cmp),
      .o_wrap_flag(flag), .o_wrap_irq(irq));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic sel, input logic [7:0] d);
      @(negedge clk);
      cwr = !sel;
      mwr = sel;
      wd = d;
      @(negedge clk);
      cwr = 1'b0;
      mwr = 1'b0;
   endtask : wr
   // Two cycles high and two low, so every source edge is seen by the sampler.
   task automatic edges(input int s, input int n);
      repeat (n) begin
         @(negedge clk);
         src[s] = 1'b1;
         repeat (2) @(negedge clk);
         src[s] = 1'b0;
         @(negedge clk);
      end
      repeat (3) @(negedge clk);
   endtask : edges
   task automatic t_reset;
      chk("status", 8'h00, st);
      chk("count", 8'h00, cnt);
      chk("compare", 8'h00, cmp);
   endtask : t_reset
   task automatic t_wrap;
      wr(0, 8'h08);
      wr(1, 8'h03);
      chk("compare", 8'h03, cmp);
      edges(0, 3);
      chk("count", 8'h03, cnt);
      edges(0, 1);
      chk("count", 8'h00, cnt);
      chk("status", 8'h88, st);
      chk("flag", 8'h01, {7'h00, flag});
      chk("irq", 8'h00, {7'h00, irq});
      wr(0, 8'h18);
      chk("status", 8'h98, st);
      chk("irq", 8'h01, {7'h00, irq});
      wr(0, 8'h98);
      chk("status", 8'h18, st);
      chk("flag", 8'h00, {7'h00, flag});
      chk("irq", 8'h00, {7'h00, irq});
   endtask : t_wrap
   task automatic t_restart;
      edges(0, 2);
      wr(0, 8'h09);
      chk("count", 8'h00, cnt);
      edges(0, 3);
      chk("count", 8'h01, cnt);
      wr(0, 8'h49);
      chk("count", 8'h00, cnt);
      edges(0, 2);
      chk("count", 8'h00, cnt);
      edges(2, 2);
      chk("count", 8'h01, cnt);
      wr(1, 8'hFF);
      chk("count", 8'h00, cnt);
      chk("compare", 8'hFF, cmp);
      wr(0, 8'h40);
      edges(2, 4);
      chk("count", 8'h00, cnt);
   endtask : t_restart
   task automatic t_slow;
      wr(0, 8'h28);
      edges(1, 999);
      chk("count", 8'h00, cnt);
      edges(1, 1);
      chk("count", 8'h01, cnt);
   endtask : t_slow
   task automatic t_zero;
      wr(1, 8'h00);
      wr(0, 8'h08);
      edges(0, 1);
      chk("status", 8'h88, st);
      wr(0, 8'h88);
      edges(0, 1);
      chk("status", 8'h88, st);
   endtask : t_zero
   // Writes and source edges while the enable is low must leave every register as it was.
   task automatic t_freeze;
      wr(1, 8'h05);
      edges(0, 2);
      chk("count", 8'h02, cnt);
      en = 1'b0;
      wr(1, 8'h09);
      edges(0, 2);
      chk("compare", 8'h05, cmp);
      chk("count", 8'h02, cnt);
      en = 1'b1;
      edges(0, 1);
      chk("count", 8'h03, cnt);
   endtask : t_freeze
   // The new source is already high when selected; that level must not count as an edge.
   task automatic t_switch;
      @(negedge clk);
      src[2] = 1'b1;
      wr(0, 8'h48);
      repeat (3) @(negedge clk);
      chk("count", 8'h00, cnt);
      src[2] = 1'b0;
      edges(2, 1);
      chk("count", 8'h01, cnt);
   endtask : t_switch
   task automatic t_midreset;
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      chk("flag", 8'h00, {7'h00, flag});
   endtask : t_midreset
   task automatic end_of_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      #100000;
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_wrap();
      t_restart();
      t_slow();
      t_zero();
      t_freeze();
      t_switch();
      t_midreset();
      end_of_test();
   end
endmodule : pit8_timer_tb
`default_nettype wire
